// ---- hw/shsfs_top.sv ----
// System handler control/state and combined fault status registers
`timescale 1ns/1ps
// What this block does
// - Bits 18..16 enable usage, bus, memory handlers.
// - Disabled handler's fault escalates to hard fault.
// - Pending bits 15..12 show pending state.
// - Writes to pending bits set pending state.
// - Active bits 11,10,8,7,3,1,0 show active state.
// - Writes to active bits set active state.
// - Active change may fault on inconsistent stack.
// - Fault word: usage 31..16, bus 15..8, memory 7..0.
// - Byte, halfword and word accesses reach sub-fields.
// - Word access at ED28 reaches whole word.
// - Byte access at ED28 reaches memory byte.
// - Halfword at ED28 reaches memory and bus.
// - Byte access at ED29 reaches bus byte.
// - Halfword at ED2A reaches usage field.
// - Memory fault flags sticky, cleared by one.
module shsfs_top
  import shsfs_pkg::*;
(
  input wire logic i_mclk, // Processor clock
  input wire logic i_reset, // Synchronous reset, active high
  input wire logic [31:0] i_addr, // Register byte address
  input wire logic [31:0] i_wdata, // Write data, low bits aligned
  input wire logic [1:0] i_size, // Access size: byte, half, word
  input wire logic i_wr, // Write strobe
  input wire logic i_rd, // Read strobe
  output logic [31:0] o_rdata, // Read data, cycle after the strobe
  input wire logic i_fault_mem, // Memory protection fault pulse
  input wire logic i_fault_bus, // Bus access fault pulse
  input wire logic i_fault_usage, // Usage fault pulse
  input wire logic [7:0] i_mem_flags, // Memory fault cause flags
  input wire logic [7:0] i_bus_flags, // Bus fault cause flags
  input wire logic [15:0] i_usage_flags, // Usage fault cause flags
  input wire logic [31:0] i_set_pend, // Core sets pending bits
  input wire logic [31:0] i_clr_pend, // Core clears pending bits
  input wire logic [31:0] i_set_act, // Core sets active bits
  input wire logic [31:0] i_clr_act, // Core clears active bits
  input wire logic i_stack_mismatch, // Core sees active state off stack
  output logic o_hard_fault, // Escalated hard fault pulse
  output logic o_mem_take, // Memory fault to own handler pulse
  output logic o_bus_take, // Bus fault to own handler pulse
  output logic o_usage_take, // Usage fault to own handler pulse
  output logic o_consistency_fault, // Fault on inconsistent active state
  output logic [31:0] o_handler_state, // Current control/state word
  output logic o_irq // Level interrupt
);

  typedef struct packed {
    logic [31:0] hcs;
    logic [31:0] cfs;
    logic [SHSFS_NUM_EV-1:0] irq_status;
    logic [SHSFS_NUM_EV-1:0] irq_mask;
    logic [31:0] rdata;
    logic hard_fault;
    logic mem_take;
    logic bus_take;
    logic usage_take;
    logic consistency_fault;
    logic act_touched;
  } shsfs_state_t;

  shsfs_state_t state;
  shsfs_state_t next_state;
  shsfs_bus_req_t req;
  shsfs_fault_t flt;
  shsfs_exc_ev_t exc;

  logic lane_hit;
  logic [3:0] lanes;
  logic [1:0] lane_shift;
  logic [31:0] lane_wdata;
  logic [31:0] lane_bmask;
  logic [31:0] fault_set;
  logic hcs_hit;
  logic [31:0] act_bits;

  assign req = '{addr: i_addr, wdata: i_wdata, size: i_size, wr: i_wr, rd: i_rd};
  assign flt = '{mem: i_fault_mem, bus: i_fault_bus, usage: i_fault_usage,
                 mem_flags: i_mem_flags, bus_flags: i_bus_flags, usage_flags: i_usage_flags};
  assign exc = '{set_pend: i_set_pend, clr_pend: i_clr_pend, set_act: i_set_act, clr_act: i_clr_act};

  shsfs_byte_lanes u_lanes (
    .i_addr(req.addr),
    .i_size(req.size),
    .o_hit(lane_hit),
    .o_lanes(lanes),
    .o_shift(lane_shift)
  );

  // Expand lane enables to a bit mask
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      assign lane_bmask[g*8 +: 8] = {8{lanes[g]}};
    end
  endgenerate

  // Move low-aligned write data onto its byte lanes
  assign lane_wdata = req.wdata << {lane_shift, 3'h0};
  assign hcs_hit = (req.addr == SHSFS_ADDR_HCS) && (req.size == SHSFS_SIZE_WORD);
  assign act_bits = (32'h1 << SHSFS_BIT_TICK_ACT) | (32'h1 << SHSFS_BIT_DEFER_ACT)
                  | (32'h1 << SHSFS_BIT_MON_ACT) | (32'h1 << SHSFS_BIT_SVC_ACT)
                  | (32'h1 << SHSFS_BIT_USAGE_ACT) | (32'h1 << SHSFS_BIT_BUS_ACT)
                  | (32'h1 << SHSFS_BIT_MEM_ACT);

  always_comb begin
    logic [31:0] hcs_w;
    logic [31:0] wclr;
    logic [SHSFS_NUM_EV-1:0] ev;
    logic [SHSFS_NUM_EV-1:0] irq_clr;
    logic esc;
    logic act_wr;
    hcs_w = 32'h0;
    wclr = 32'h0;
    ev = '0;
    irq_clr = '0;
    esc = 1'b0;
    act_wr = 1'b0;
    next_state = state;
    next_state.hard_fault = 1'b0;
    next_state.mem_take = 1'b0;
    next_state.bus_take = 1'b0;
    next_state.usage_take = 1'b0;
    next_state.consistency_fault = 1'b0;
    next_state.rdata = 32'h0;

    // Core-driven pending/active changes; software write below may override
    hcs_w = (state.hcs | exc.set_pend | exc.set_act) & ~exc.clr_pend & ~exc.clr_act;

    // Fault routing: own handler when enabled, hard fault otherwise
    if (flt.mem) begin
      if (state.hcs[SHSFS_BIT_MEM_EN]) begin
        next_state.mem_take = 1'b1;
        hcs_w[SHSFS_BIT_MEM_PEND] = 1'b1;
      end else begin
        esc = 1'b1;
      end
    end
    if (flt.bus) begin
      if (state.hcs[SHSFS_BIT_BUS_EN]) begin
        next_state.bus_take = 1'b1;
        hcs_w[SHSFS_BIT_BUS_PEND] = 1'b1;
      end else begin
        esc = 1'b1;
      end
    end
    if (flt.usage) begin
      if (state.hcs[SHSFS_BIT_USAGE_EN]) begin
        next_state.usage_take = 1'b1;
        hcs_w[SHSFS_BIT_USAGE_PEND] = 1'b1;
      end else begin
        esc = 1'b1;
      end
    end
    next_state.hard_fault = esc;

    // Software write to control/state replaces enable, pending and active bits
    if (req.wr && hcs_hit) begin
      hcs_w = req.wdata;
      if (((req.wdata ^ state.hcs) & act_bits) != 32'h0) begin
        act_wr = 1'b1;
      end
    end
    next_state.hcs = hcs_w & SHSFS_HCS_MASK;

    // Active edit not backed by the stack: raise once when core reports it
    if (state.act_touched && i_stack_mismatch) begin
      next_state.consistency_fault = 1'b1;
      next_state.act_touched = 1'b0;
    end else if (state.act_touched && (exc.set_act != 32'h0 || exc.clr_act != 32'h0)) begin
      next_state.act_touched = 1'b0;
    end
    // A fresh active edit beats a same-cycle clear, so it is never lost
    if (act_wr) begin
      next_state.act_touched = 1'b1;
    end

    // Fault status: write-one-to-clear on reached lanes, new flags win
    if (req.wr && lane_hit) begin
      wclr = lane_wdata & lane_bmask;
    end
    fault_set = 32'h0;
    if (flt.mem) begin
      fault_set[7:0] = flt.mem_flags;
    end
    if (flt.bus) begin
      fault_set[15:8] = flt.bus_flags;
    end
    if (flt.usage) begin
      fault_set[31:16] = flt.usage_flags;
    end
    next_state.cfs = (state.cfs & ~wclr) | fault_set;

    // Interrupt bookkeeping
    ev[SHSFS_EV_MEM] = flt.mem;
    ev[SHSFS_EV_BUS] = flt.bus;
    ev[SHSFS_EV_USAGE] = flt.usage;
    ev[SHSFS_EV_ESCALATE] = esc;
    if (req.wr && req.addr == SHSFS_ADDR_IRQ_STATUS) begin
      irq_clr = req.wdata[SHSFS_NUM_EV-1:0];
    end
    if (req.wr && req.addr == SHSFS_ADDR_IRQ_MASK) begin
      next_state.irq_mask = req.wdata[SHSFS_NUM_EV-1:0];
    end
    // Set beats clear so a same-cycle event is kept
    next_state.irq_status = (state.irq_status & ~irq_clr) | ev;

    // Read data, shown the cycle after the strobe
    if (req.rd) begin
      if (hcs_hit) begin
        next_state.rdata = state.hcs & SHSFS_HCS_MASK;
      end else if (lane_hit) begin
        next_state.rdata = (state.cfs & lane_bmask) >> {lane_shift, 3'h0};
      end else if (req.addr == SHSFS_ADDR_IRQ_STATUS) begin
        next_state.rdata = {28'h0, state.irq_status};
      end else if (req.addr == SHSFS_ADDR_IRQ_MASK) begin
        next_state.rdata = {28'h0, state.irq_mask};
      end else begin
        next_state.rdata = 32'h0;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      state <= '{hcs: SHSFS_HCS_RESET, cfs: SHSFS_CFS_RESET, irq_status: SHSFS_IRQ_RESET,
                 irq_mask: SHSFS_IRQ_RESET, rdata: 32'h0, hard_fault: 1'b0, mem_take: 1'b0,
                 bus_take: 1'b0, usage_take: 1'b0, consistency_fault: 1'b0, act_touched: 1'b0};
    end else begin
      state <= next_state;
    end
  end

  assign o_rdata = state.rdata;
  assign o_hard_fault = state.hard_fault;
  assign o_mem_take = state.mem_take;
  assign o_bus_take = state.bus_take;
  assign o_usage_take = state.usage_take;
  assign o_consistency_fault = state.consistency_fault;
  assign o_handler_state = state.hcs;
  assign o_irq = |(state.irq_status & state.irq_mask);

endmodule : shsfs_top

// ---- hw/shsfs_pkg.sv ----
// Package for the system handler state and fault status block
package shsfs_pkg;

  localparam logic [31:0] SHSFS_ADDR_HCS = 32'hE000ED24;
  localparam logic [31:0] SHSFS_ADDR_CFS = 32'hE000ED28;
  localparam logic [31:0] SHSFS_ADDR_BFS = 32'hE000ED29;
  localparam logic [31:0] SHSFS_ADDR_UFS = 32'hE000ED2A;
  localparam logic [31:0] SHSFS_ADDR_IRQ_STATUS = 32'hE000EF00;
  localparam logic [31:0] SHSFS_ADDR_IRQ_MASK = 32'hE000EF04;

  localparam logic [1:0] SHSFS_SIZE_BYTE = 2'h0;
  localparam logic [1:0] SHSFS_SIZE_HALF = 2'h1;
  localparam logic [1:0] SHSFS_SIZE_WORD = 2'h2;

  localparam int SHSFS_BIT_USAGE_EN = 18;
  localparam int SHSFS_BIT_BUS_EN = 17;
  localparam int SHSFS_BIT_MEM_EN = 16;
  localparam int SHSFS_BIT_SVC_PEND = 15;
  localparam int SHSFS_BIT_BUS_PEND = 14;
  localparam int SHSFS_BIT_MEM_PEND = 13;
  localparam int SHSFS_BIT_USAGE_PEND = 12;
  localparam int SHSFS_BIT_TICK_ACT = 11;
  localparam int SHSFS_BIT_DEFER_ACT = 10;
  localparam int SHSFS_BIT_MON_ACT = 8;
  localparam int SHSFS_BIT_SVC_ACT = 7;
  localparam int SHSFS_BIT_USAGE_ACT = 3;
  localparam int SHSFS_BIT_BUS_ACT = 1;
  localparam int SHSFS_BIT_MEM_ACT = 0;

  // Implemented bits of the handler control and state word
  localparam logic [31:0] SHSFS_HCS_MASK = 32'h0007FD8B;
  localparam logic [31:0] SHSFS_HCS_RESET = 32'h00000000;
  localparam logic [31:0] SHSFS_CFS_RESET = 32'h00000000;
  localparam logic [3:0] SHSFS_IRQ_RESET = 4'h0;

  // Interrupt event bits
  localparam int SHSFS_EV_MEM = 0;
  localparam int SHSFS_EV_BUS = 1;
  localparam int SHSFS_EV_USAGE = 2;
  localparam int SHSFS_EV_ESCALATE = 3;
  localparam int SHSFS_NUM_EV = 4;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [1:0] size;
    logic wr;
    logic rd;
  } shsfs_bus_req_t;

  // Fault report from the core: which class faulted and its status flags
  typedef struct packed {
    logic mem;
    logic bus;
    logic usage;
    logic [7:0] mem_flags;
    logic [7:0] bus_flags;
    logic [15:0] usage_flags;
  } shsfs_fault_t;

  // Exception entry/exit events (one-cycle pulses) from the core
  typedef struct packed {
    logic [31:0] set_pend;
    logic [31:0] clr_pend;
    logic [31:0] set_act;
    logic [31:0] clr_act;
  } shsfs_exc_ev_t;

endpackage : shsfs_pkg

// ---- hw/shsfs_byte_lanes.sv ----
// Byte lane decoder for sized accesses to the combined fault status word
`timescale 1ns/1ps
module shsfs_byte_lanes
  import shsfs_pkg::*;
(
  input wire logic [31:0] i_addr, // Byte address
  input wire logic [1:0] i_size, // Access size
  output logic o_hit, // Address and size match a legal view
  output logic [3:0] o_lanes, // Byte lanes reached
  output logic [1:0] o_shift // Byte lane of the low data byte
);

  always_comb begin
    o_hit = 1'b0;
    o_lanes = 4'h0;
    o_shift = 2'h0;
    unique case (i_size)
      SHSFS_SIZE_WORD: begin
        if (i_addr == SHSFS_ADDR_CFS) begin
          o_hit = 1'b1;
          o_lanes = 4'hF;
        end
      end
      SHSFS_SIZE_HALF: begin
        if (i_addr == SHSFS_ADDR_CFS) begin
          o_hit = 1'b1;
          o_lanes = 4'h3;
        end else if (i_addr == SHSFS_ADDR_UFS) begin
          o_hit = 1'b1;
          o_lanes = 4'hC;
          o_shift = 2'h2;
        end
      end
      SHSFS_SIZE_BYTE: begin
        if (i_addr == SHSFS_ADDR_CFS) begin
          o_hit = 1'b1;
          o_lanes = 4'h1;
        end else if (i_addr == SHSFS_ADDR_BFS) begin
          o_hit = 1'b1;
          o_lanes = 4'h2;
          o_shift = 2'h1;
        end
      end
      default: begin
        o_hit = 1'b0;
      end
    endcase
  end

endmodule : shsfs_byte_lanes

// ---- tb/shsfs_asserts.sv ----
// Concurrent checks on the handler state and fault status block ports
`timescale 1ns/1ps
module shsfs_asserts
  import shsfs_pkg::*;
(
  input wire logic i_mclk, // Clock
  input wire logic i_reset, // Reset
  input wire logic [31:0] i_addr, // Address
  input wire logic [31:0] i_wdata, // Write data
  input wire logic [1:0] i_size, // Size
  input wire logic i_wr, // Write strobe
  input wire logic i_rd, // Read strobe
  input wire logic [31:0] o_rdata, // Read data
  input wire logic i_fault_mem, // Memory fault
  input wire logic i_fault_bus, // Bus fault
  input wire logic i_fault_usage, // Usage fault
  input wire logic [31:0] i_clr_pend, // Core pending clears
  input wire logic [31:0] i_set_act, // Core active sets
  input wire logic [31:0] i_clr_act, // Core active clears
  input wire logic i_stack_mismatch, // Stack mismatch
  input wire logic o_hard_fault, // Escalation pulse
  input wire logic o_bus_take, // Bus handler pulse
  input wire logic o_consistency_fault, // Consistency pulse
  input wire logic [31:0] o_handler_state, // Control/state word
  input wire logic o_irq // Interrupt
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);

  sequence act_wr_s;
    i_wr && i_addr == SHSFS_ADDR_HCS && i_size == SHSFS_SIZE_WORD && ((i_wdata ^ o_handler_state) & 32'h00000D8B) != 0;
  endsequence
  sequence mism_s;
    i_stack_mismatch && i_set_act == 32'h0 && i_clr_act == 32'h0;
  endsequence

  rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data not zero outside read answer");
  hcs_write_a: assert property (i_wr && i_addr == SHSFS_ADDR_HCS && i_size == SHSFS_SIZE_WORD
    |=> o_handler_state == ($past(i_wdata) & SHSFS_HCS_MASK)) else $error("control word write lost");
  reserved_zero_a: assert property ((o_handler_state & ~SHSFS_HCS_MASK) == 32'h0)
    else $error("reserved control bit set");
  escalate_a: assert property ((i_fault_mem && !o_handler_state[16]) || (i_fault_bus && !o_handler_state[17])
    || (i_fault_usage && !o_handler_state[18]) |=> o_hard_fault) else $error("disabled fault not escalated");
  own_handler_a: assert property (i_fault_bus && o_handler_state[17] && !i_fault_mem && !i_fault_usage
    |=> o_bus_take && !o_hard_fault) else $error("enabled bus fault not routed");
  pend_on_fault_a: assert property (i_fault_bus && o_handler_state[17] && !i_wr && i_clr_pend == 32'h0
    |=> o_handler_state[14]) else $error("bus pending bit not set");
  consistency_a: assert property (act_wr_s ##1 mism_s |=> o_consistency_fault)
    else $error("no fault on inconsistent active state");
  irq_mask_a: assert property (i_wr && i_addr == SHSFS_ADDR_IRQ_MASK && i_wdata[3:0] == 4'h0 |=> !o_irq)
    else $error("interrupt high while all masked");
endmodule : shsfs_asserts

bind shsfs_top shsfs_asserts i_chk (.i_mclk(i_mclk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_size(i_size), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_fault_mem(i_fault_mem),
  .i_fault_bus(i_fault_bus), .i_fault_usage(i_fault_usage), .i_clr_pend(i_clr_pend), .i_set_act(i_set_act),
  .i_clr_act(i_clr_act), .i_stack_mismatch(i_stack_mismatch), .o_hard_fault(o_hard_fault),
  .o_bus_take(o_bus_take), .o_consistency_fault(o_consistency_fault), .o_handler_state(o_handler_state),
  .o_irq(o_irq));

// ---- tb/shsfs_top_tb.sv ----
// Self-checking bench for the handler state and fault status block
`timescale 1ns/1ps
module shsfs_top_tb
  import shsfs_pkg::*;
;
  logic i_mclk = 1'b0, i_reset = 1'b1, i_wr = 1'b0, i_rd = 1'b0, i_stack_mismatch = 1'b0;
  logic i_fault_mem = 1'b0, i_fault_bus = 1'b0, i_fault_usage = 1'b0;
  logic [1:0] i_size = 2'h0;
  logic [7:0] i_mem_flags = 8'h0, i_bus_flags = 8'h0, m, b;
  logic [15:0] i_usage_flags = 16'h0, u;
  logic [31:0] i_addr = 32'h0, i_wdata = 32'h0, i_set_pend = 32'h0, i_clr_pend = 32'h0, d;
  logic [31:0] i_set_act = 32'h0, i_clr_act = 32'h0, o_rdata, o_handler_state;
  logic o_hard_fault, o_mem_take, o_bus_take, o_usage_take, o_consistency_fault, o_irq;
  logic rd_q = 1'b0, seen_hf = 1'b0, seen_cf = 1'b0, seen_mt = 1'b0, seen_ut = 1'b0;
  logic [31:0] exp_q[$];
  int err_count = 0, compares = 0, cyc = 0;

  shsfs_top i_dut (
    .i_mclk(i_mclk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata), .i_size(i_size), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_fault_mem(i_fault_mem), .i_fault_bus(i_fault_bus),
    .i_fault_usage(i_fault_usage), .i_mem_flags(i_mem_flags), .i_bus_flags(i_bus_flags),
    .i_usage_flags(i_usage_flags), .i_set_pend(i_set_pend), .i_clr_pend(i_clr_pend), .i_set_act(i_set_act),
    .i_clr_act(i_clr_act), .i_stack_mismatch(i_stack_mismatch), .o_hard_fault(o_hard_fault),
    .o_mem_take(o_mem_take), .o_bus_take(o_bus_take), .o_usage_take(o_usage_take),
    .o_consistency_fault(o_consistency_fault), .o_handler_state(o_handler_state), .o_irq(o_irq)
  );

  initial begin
    forever #20 i_mclk = ~i_mclk;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic end_of_test();
    $display("Compares %0d, errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test

  // Strobes are always both assigned, so calls may follow back to back
  task automatic acc(input logic w, input logic [31:0] a, input logic [1:0] s, input logic [31:0] dat);
    i_wr <= w;
    i_rd <= ~w;
    i_addr <= a;
    i_size <= s;
    i_wdata <= dat;
    @(posedge i_mclk);
  endtask : acc

  task automatic rd(input logic [31:0] a, input logic [1:0] s, input logic [31:0] e);
    exp_q.push_back(e);
    acc(1'b0, a, s, 32'h0);
  endtask : rd

  task automatic idle(input int n);
    i_wr <= 1'b0;
    i_rd <= 1'b0;
    repeat (n) @(posedge i_mclk);
  endtask : idle

  // Pulses last one cycle and a spare edge follows, so calls never collide
  task automatic pulse(input logic [2:0] k, input logic [31:0] f, input logic [31:0] sp, cp, sa, ca, input logic sm);
    {i_fault_mem, i_fault_bus, i_fault_usage} <= k;
    {i_usage_flags, i_bus_flags, i_mem_flags} <= f;
    {i_set_pend, i_clr_pend, i_set_act, i_clr_act, i_stack_mismatch} <= {sp, cp, sa, ca, sm};
    idle(1);
    {i_fault_mem, i_fault_bus, i_fault_usage} <= 3'h0;
    {i_set_pend, i_clr_pend, i_set_act, i_clr_act, i_stack_mismatch} <= 129'h0;
    @(posedge i_mclk);
  endtask : pulse

  always @(posedge i_mclk) begin
    rd_q <= i_rd;
    cyc <= cyc + 1;
    if (o_hard_fault) seen_hf <= 1'b1;
    if (o_consistency_fault) seen_cf <= 1'b1;
    if (o_mem_take) seen_mt <= 1'b1;
    if (o_usage_take) seen_ut <= 1'b1;
    if (cyc == 2000) begin
      err_count++;
      end_of_test();
    end
  end

  always @(negedge i_mclk) begin
    if (rd_q) begin
      check("rdata", o_rdata, exp_q.pop_front());
    end
  end

  initial begin
    d = $urandom(32'h8d5b6af3);
    repeat (5) @(posedge i_mclk);
    i_reset <= 1'b0;
    rd(SHSFS_ADDR_HCS, SHSFS_SIZE_WORD, SHSFS_HCS_RESET);
    rd(SHSFS_ADDR_CFS, SHSFS_SIZE_WORD, SHSFS_CFS_RESET);
    repeat (4) begin
      d = $urandom();
      acc(1'b1, SHSFS_ADDR_HCS, SHSFS_SIZE_WORD, d);
      rd(SHSFS_ADDR_HCS, SHSFS_SIZE_WORD, d & SHSFS_HCS_MASK);
    end
    acc(1'b1, SHSFS_ADDR_HCS, SHSFS_SIZE_WORD, 32'h0);
    m = 8'($urandom()) | 8'h01;
    b = 8'($urandom()) | 8'h01;
    u = 16'($urandom()) | 16'h0001;
    pulse(3'h4, {24'h0, m}, 0, 0, 0, 0, 1'b0);
    pulse(3'h2, {16'h0, b, 8'h0}, 0, 0, 0, 0, 1'b0);
    pulse(3'h1, {u, 16'h0}, 0, 0, 0, 0, 1'b0);
    check("hard", {31'h0, seen_hf}, 32'h1);
    rd(SHSFS_ADDR_IRQ_STATUS, SHSFS_SIZE_WORD, 32'hF);
    rd(SHSFS_ADDR_CFS, SHSFS_SIZE_WORD, {u, b, m});
    rd(SHSFS_ADDR_CFS, SHSFS_SIZE_BYTE, {24'h0, m});
    rd(SHSFS_ADDR_CFS, SHSFS_SIZE_HALF, {16'h0, b, m});
    rd(SHSFS_ADDR_BFS, SHSFS_SIZE_BYTE, {24'h0, b});
    rd(SHSFS_ADDR_UFS, SHSFS_SIZE_HALF, {16'h0, u});
    rd(SHSFS_ADDR_CFS, 2'h3, 32'h0);
    rd(SHSFS_ADDR_UFS, SHSFS_SIZE_WORD, 32'h0);
    acc(1'b1, SHSFS_ADDR_BFS, SHSFS_SIZE_BYTE, {24'h0, b});
    acc(1'b1, SHSFS_ADDR_CFS, SHSFS_SIZE_BYTE, 32'h0000000F);
    acc(1'b1, SHSFS_ADDR_UFS, SHSFS_SIZE_HALF, 32'h0000FFFF);
    pulse(3'h4, 32'h00000080, 0, 0, 0, 0, 1'b0);
    rd(SHSFS_ADDR_CFS, SHSFS_SIZE_WORD, {24'h0, (m & 8'hF0) | 8'h80});
    acc(1'b1, SHSFS_ADDR_CFS, SHSFS_SIZE_WORD, 32'hFFFFFFFF);
    rd(SHSFS_ADDR_CFS, SHSFS_SIZE_WORD, 32'h0);
    acc(1'b1, SHSFS_ADDR_IRQ_MASK, SHSFS_SIZE_WORD, 32'h0);
    idle(1);
    #1 check("irq", {31'h0, o_irq}, 32'h0);
    acc(1'b1, SHSFS_ADDR_IRQ_MASK, SHSFS_SIZE_WORD, 32'h1);
    idle(1);
    #1 check("irq", {31'h0, o_irq}, 32'h1);
    acc(1'b1, SHSFS_ADDR_IRQ_STATUS, SHSFS_SIZE_WORD, 32'h1);
    idle(1);
    #1 check("irq", {31'h0, o_irq}, 32'h0);
    rd(SHSFS_ADDR_IRQ_STATUS, SHSFS_SIZE_WORD, 32'hE);
    acc(1'b1, SHSFS_ADDR_HCS, SHSFS_SIZE_WORD, 32'h00070000);
    pulse(3'h2, 32'h00000100, 0, 0, 0, 0, 1'b0);
    rd(SHSFS_ADDR_HCS, SHSFS_SIZE_WORD, 32'h00074000);
    pulse(3'h0, 0, 32'h00008000, 0, 32'h00000800, 0, 1'b0);
    rd(SHSFS_ADDR_HCS, SHSFS_SIZE_WORD, 32'h0007C800);
    pulse(3'h0, 0, 0, 32'h0000C000, 0, 32'h00000800, 1'b0);
    rd(SHSFS_ADDR_HCS, SHSFS_SIZE_WORD, 32'h00070000);
    acc(1'b1, SHSFS_ADDR_HCS, SHSFS_SIZE_WORD, 32'h00070001);
    pulse(3'h0, 0, 0, 0, 0, 0, 1'b1);
    pulse(3'h5, 0, 0, 0, 0, 0, 1'b0);
    idle(1);
    check("consistency", {31'h0, seen_cf}, 32'h1);
    check("mem take", {31'h0, seen_mt}, 32'h1);
    check("usage take", {31'h0, seen_ut}, 32'h1);
    rd(SHSFS_ADDR_HCS, SHSFS_SIZE_WORD, 32'h00073001);
    idle(2);
    end_of_test();
  end
endmodule : shsfs_top_tb
